// ### verilog/video_cfg_defines.vh
/*
 Constants for the video input gain/offset configuration bank.
 Assumes inclusion by bare name from the design files.
*/
`ifndef VIDEO_CFG_DEFINES_VH
`define VIDEO_CFG_DEFINES_VH
// Register indices as printed; byte address is four times the index
`define IDX_INPUT_CFG      8'h05
`define IDX_RED_GAIN       8'h06
`define IDX_GREEN_GAIN     8'h07
`define IDX_BLUE_GAIN      8'h08
`define IDX_RED_OFFSET     8'h09
`define IDX_GREEN_OFFSET   8'h0a
`define IDX_BLUE_OFFSET    8'h0b
`define IDX_OFFSET_SETUP   8'h0c
// Reset values
`define RST_INPUT_CFG      8'h00
`define RST_GAIN           8'h55
`define RST_OFFSET         8'h80
`define RST_OFFSET_SETUP   8'h00
// Input configuration fields
`define BIT_CHANNEL_SEL    0
`define BIT_COUPLING       1
`define BIT_COLOUR_SPACE   2
`define BIT_SYNC_TYPE      3
`define BIT_COMPOSITE_SYNC_SIGNAL_SOURCE   4
`define BIT_HOLDOVER_CLAMP 5
// Offset converter setup fields
`define BIT_RANGE          0
`define LSB_RED            2
`define LSB_GREEN          4
`define LSB_BLUE           6
// Clamp level codes and black targets
`define CLAMP_300MV        1'b0
`define CLAMP_600MV        1'b1
`define BLACK_ZERO         8'h00
`define BLACK_MID          8'h80
// Gain: 0.5 + code/170, in units of 1/340
`define GAIN_BASE          10'h0aa
`define GAIN_DIV           10'h0aa
`endif

// ### verilog/channel_setup.v
/*
 Per-channel path setup: gain numerator, offset converter word and digital offset.
 Assumes configuration inputs come from registered values in the same clock domain.
*/
`timescale 1ns/10ps
`include "video_cfg_defines.vh"
module channel_setup (
	input  wire        pclk,            // Clock
	input  wire        presetn,         // Async reset, active low
	input  wire [7:0]  gain_code,       // Gain code
	input  wire [7:0]  offset_code,     // Offset code
	input  wire [1:0]  offset_lsbs,     // Extra offset converter bits
	input  wire        auto_black,      // Auto black compensation on
	input  wire        range_quarter,   // Offset converter range select
	output reg  [9:0]  gain_num,        // Gain times 340
	output reg  [9:0]  offset_dac,      // Offset converter word
	output reg  [8:0]  digital_offset,  // Signed digital offset, output counts
	output reg  [1:0]  dac_step_shift   // Output counts per step: 0 full, 1 half
);
	// Registered per-channel path values
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_num       <= 10'h154;
			offset_dac     <= 10'h200;
			digital_offset <= 9'h000;
			dac_step_shift <= 2'h0;
		end else begin
			gain_num <= `GAIN_BASE + {1'b0, gain_code, 1'b0};
			// Manual mode: code on top, low bits below
			offset_dac <= auto_black ? 10'h200 : {offset_code, offset_lsbs};
			// Digital offset with auto black on: code minus 0x80, one count per step; zero in manual mode
			digital_offset <= auto_black ?
				{~offset_code[7], ~offset_code[7], offset_code[6:0]} : 9'h000;
			dac_step_shift <= {1'b0, range_quarter};
		end
	end
endmodule

// ### verilog/video_input_gain_offset_config.v
/*
 Gain, offset and input configuration register bank with an APB slave.
 Eight byte-wide registers sit at word indices 0x05 to 0x0c; each takes
 the low byte of one aligned 32-bit word. From the registers it derives
 the clamp controls, the colour space set-up, the sync multiplexer and,
 through one channel_setup instance per colour, the gain, offset converter
 and digital offset words of the three channel paths.
 Assumes an APB master on pclk that holds each request until pready;
 pready is tied high, so every access completes in its first access cycle.
 Assumes the analog front end consumes the outputs in the pclk domain and
 that the front end level inputs are already synchronous to pclk.
*/
`timescale 1ns/10ps
`include "video_cfg_defines.vh"
module video_input_gain_offset_config (
	input  wire        pclk,                       // Clock, 20 MHz
	input  wire        presetn,                    // Async reset, active low
	input  wire        psel,                       // APB select
	input  wire        penable,                    // APB enable
	input  wire        pwrite,                     // APB direction
	input  wire [7:0]  paddr,                      // APB byte address
	input  wire [31:0] pwdata,                     // APB write data
	output wire [31:0] prdata,                     // APB read data
	output wire        pready,                     // APB ready
	output wire        pslverr,                    // APB error
	input  wire        clamp_interval,             // Clamp window
	input  wire        holdover,                   // Clock loop holdover window
	input  wire        auto_black_en,              // Auto black compensation request
	input  wire        hsync_pin,                  // Horizontal sync pin
	input  wire        green_embedded_sync_input,  // Sync from green
	output reg         channel_select,             // Input pair select
	output reg         clamp_pos_connect,          // Positive input to clamp
	output reg         neg_to_clamp,               // Negative input tied to clamp
	output reg         clamp_active,               // Clamp control
	output reg         auto_black_active,          // Auto black compensation running
	output reg  [2:0]  clamp_level_600mv,          // Clamp level per channel {b,g,r}
	output reg  [2:0]  half_scale_shift,           // Shift per channel {b,g,r}
	output reg  [23:0] black_target,               // Targets {b,g,r}
	output reg         separate_sync,              // Separate syncs in use
	output reg         composite_sync_signal,      // Sync multiplexer output
	output wire [29:0] gain_num,                   // Gains x340 {b,g,r}
	output wire [29:0] offset_dac,                 // Converter words {b,g,r}
	output wire [26:0] digital_offset,             // Digital offsets {b,g,r}
	output wire [5:0]  dac_step_shift              // Step size {b,g,r}
);
	reg  [7:0] input_configuration_reg;
	reg  [7:0] red_gain_code_reg;
	reg  [7:0] green_gain_code_reg;
	reg  [7:0] blue_gain_code_reg;
	reg  [7:0] red_offset_code_reg;
	reg  [7:0] green_offset_code_reg;
	reg  [7:0] blue_offset_code_reg;
	reg  [7:0] offset_converter_setup_reg;
	reg  [7:0] rd_next;
	reg        hit;
	wire [7:0] idx;
	wire       wr_en;
	wire       cfg_dc;
	wire       cfg_yuv;
	wire       cfg_ctype;
	wire       cfg_csrc;
	wire       cfg_hold;
	wire       run_restore;
	wire       wr_input_cfg;
	wire       wr_red_gain;
	wire       wr_green_gain;
	wire       wr_blue_gain;
	wire       wr_red_offset;
	wire       wr_green_offset;
	wire       wr_blue_offset;
	wire       wr_offset_setup;

	// APB slave: no wait states, so pready is constant high.
	// Unmapped indices answer with pslverr and read as zero; writes to
	// them are dropped because wr_en requires a decoded hit.
	assign idx    = {2'b00, paddr[7:2]};
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wr_en  = psel & penable & pwrite & hit;
	assign prdata = {24'h0000_00, (psel & ~pwrite & hit) ? rd_next : 8'h00};
	// Address decode and read mux
	always @* begin
		hit     = 1'b1;
		rd_next = 8'h00;
		case (idx)
			`IDX_INPUT_CFG:    rd_next = input_configuration_reg;
			`IDX_RED_GAIN:     rd_next = red_gain_code_reg;
			`IDX_GREEN_GAIN:   rd_next = green_gain_code_reg;
			`IDX_BLUE_GAIN:    rd_next = blue_gain_code_reg;
			`IDX_RED_OFFSET:   rd_next = red_offset_code_reg;
			`IDX_GREEN_OFFSET: rd_next = green_offset_code_reg;
			`IDX_BLUE_OFFSET:  rd_next = blue_offset_code_reg;
			`IDX_OFFSET_SETUP: rd_next = offset_converter_setup_reg;
			default:           hit = 1'b0;
		endcase
	end

	// One write strobe per register; wr_en already requires a mapped index
	assign wr_input_cfg    = wr_en & (idx == `IDX_INPUT_CFG);
	assign wr_red_gain     = wr_en & (idx == `IDX_RED_GAIN);
	assign wr_green_gain   = wr_en & (idx == `IDX_GREEN_GAIN);
	assign wr_blue_gain    = wr_en & (idx == `IDX_BLUE_GAIN);
	assign wr_red_offset   = wr_en & (idx == `IDX_RED_OFFSET);
	assign wr_green_offset = wr_en & (idx == `IDX_GREEN_OFFSET);
	assign wr_blue_offset  = wr_en & (idx == `IDX_BLUE_OFFSET);
	assign wr_offset_setup = wr_en & (idx == `IDX_OFFSET_SETUP);

	// Input configuration; reserved bits are stored as written
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_configuration_reg <= `RST_INPUT_CFG;
		end else if (wr_input_cfg) begin
			input_configuration_reg <= pwdata[7:0];
		end
	end

	// Red gain code, unity by default
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			red_gain_code_reg <= `RST_GAIN;
		end else if (wr_red_gain) begin
			red_gain_code_reg <= pwdata[7:0];
		end
	end

	// Green gain code, unity by default
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			green_gain_code_reg <= `RST_GAIN;
		end else if (wr_green_gain) begin
			green_gain_code_reg <= pwdata[7:0];
		end
	end

	// Blue gain code, unity by default
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blue_gain_code_reg <= `RST_GAIN;
		end else if (wr_blue_gain) begin
			blue_gain_code_reg <= pwdata[7:0];
		end
	end

	// Red offset code, mid-scale by default
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			red_offset_code_reg <= `RST_OFFSET;
		end else if (wr_red_offset) begin
			red_offset_code_reg <= pwdata[7:0];
		end
	end

	// Green offset code, mid-scale by default
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			green_offset_code_reg <= `RST_OFFSET;
		end else if (wr_green_offset) begin
			green_offset_code_reg <= pwdata[7:0];
		end
	end

	// Blue offset code, mid-scale by default
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blue_offset_code_reg <= `RST_OFFSET;
		end else if (wr_blue_offset) begin
			blue_offset_code_reg <= pwdata[7:0];
		end
	end

	// Offset converter setup: range bit and the low offset bits per channel
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offset_converter_setup_reg <= `RST_OFFSET_SETUP;
		end else if (wr_offset_setup) begin
			offset_converter_setup_reg <= pwdata[7:0];
		end
	end

	// Input configuration fields used by the front end controls
	assign cfg_dc    = input_configuration_reg[`BIT_COUPLING];
	assign cfg_yuv   = input_configuration_reg[`BIT_COLOUR_SPACE];
	assign cfg_ctype = input_configuration_reg[`BIT_SYNC_TYPE];
	assign cfg_csrc  = input_configuration_reg[`BIT_COMPOSITE_SYNC_SIGNAL_SOURCE];
	assign cfg_hold  = input_configuration_reg[`BIT_HOLDOVER_CLAMP];
	// Restore may run unless holdover suspends it
	assign run_restore = ~holdover | cfg_hold;

	// Channel select follows bit 0 of the input configuration
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_select <= 1'b0;
		end else begin
			channel_select <= input_configuration_reg[`BIT_CHANNEL_SEL];
		end
	end

	// Clamp switches: AC closes the positive input only in the window, DC never
	// Negative input stays tied to its clamp level whenever AC coupled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clamp_active      <= 1'b0;
			clamp_pos_connect <= 1'b0;
			neg_to_clamp      <= 1'b1;
		end else begin
			clamp_active      <= ~cfg_dc & clamp_interval & run_restore;
			clamp_pos_connect <= ~cfg_dc & clamp_interval & run_restore;
			neg_to_clamp      <= ~cfg_dc;
		end
	end

	// Auto black compensation runs on request unless holdover suspends it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_black_active <= 1'b0;
		end else begin
			auto_black_active <= auto_black_en & run_restore;
		end
	end

	// Colour space: clamp levels, shifts and black targets per channel {b,g,r}
	// YUV moves red and blue to mid-scale, so only green keeps the shift
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clamp_level_600mv <= 3'b000;
			half_scale_shift  <= 3'b111;
			black_target      <= 24'h0000_00;
		end else begin
			clamp_level_600mv <= cfg_yuv ? {`CLAMP_600MV, `CLAMP_300MV, `CLAMP_600MV}
				: {3{`CLAMP_300MV}};
			half_scale_shift  <= cfg_yuv ? 3'b010 : 3'b111;
			black_target      <= cfg_yuv ? {`BLACK_MID, `BLACK_ZERO, `BLACK_MID}
				: {3{`BLACK_ZERO}};
		end
	end

	// Sync multiplexer: green sync only for composite type from the green source
	// With separate syncs the horizontal pin passes whatever bit 4 holds
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			separate_sync         <= 1'b1;
			composite_sync_signal <= 1'b0;
		end else begin
			separate_sync         <= ~cfg_ctype;
			composite_sync_signal <= (cfg_ctype & ~cfg_csrc) ?
				green_embedded_sync_input : hsync_pin;
		end
	end

	// Red path: offset code with setup bits 3:2 below it
	channel_setup red_ch (
		.pclk           (pclk),
		.presetn        (presetn),
		.gain_code      (red_gain_code_reg),
		.offset_code    (red_offset_code_reg),
		.offset_lsbs    (offset_converter_setup_reg[`LSB_RED+1:`LSB_RED]),
		.auto_black     (auto_black_en),
		.range_quarter  (offset_converter_setup_reg[`BIT_RANGE]),
		.gain_num       (gain_num[9:0]),
		.offset_dac     (offset_dac[9:0]),
		.digital_offset (digital_offset[8:0]),
		.dac_step_shift (dac_step_shift[1:0])
	);

	// Green path: offset code with setup bits 5:4 below it
	channel_setup green_ch (
		.pclk           (pclk),
		.presetn        (presetn),
		.gain_code      (green_gain_code_reg),
		.offset_code    (green_offset_code_reg),
		.offset_lsbs    (offset_converter_setup_reg[`LSB_GREEN+1:`LSB_GREEN]),
		.auto_black     (auto_black_en),
		.range_quarter  (offset_converter_setup_reg[`BIT_RANGE]),
		.gain_num       (gain_num[19:10]),
		.offset_dac     (offset_dac[19:10]),
		.digital_offset (digital_offset[17:9]),
		.dac_step_shift (dac_step_shift[3:2])
	);

	// Blue path: offset code with setup bits 7:6 below it
	channel_setup blue_ch (
		.pclk           (pclk),
		.presetn        (presetn),
		.gain_code      (blue_gain_code_reg),
		.offset_code    (blue_offset_code_reg),
		.offset_lsbs    (offset_converter_setup_reg[`LSB_BLUE+1:`LSB_BLUE]),
		.auto_black     (auto_black_en),
		.range_quarter  (offset_converter_setup_reg[`BIT_RANGE]),
		.gain_num       (gain_num[29:20]),
		.offset_dac     (offset_dac[29:20]),
		.digital_offset (digital_offset[26:18]),
		.dac_step_shift (dac_step_shift[5:4])
	);
endmodule

// ### bench/video_cfg_props.sv
/* Checker for the configuration bank outputs against its inputs.
   Assumes binding to the bank top; one clock domain. */
`timescale 1ns/10ps
module video_cfg_props (
	input wire logic        pclk,                  // Clock
	input wire logic        presetn,               // Reset, active low
	input wire logic        psel,                  // Select
	input wire logic        penable,               // Enable
	input wire logic [7:0]  paddr,                 // Byte address
	input wire logic [31:0] prdata,                // Read data
	input wire logic        pslverr,               // Error
	input wire logic        clamp_interval,        // Clamp window
	input wire logic        auto_black_en,         // Auto black request
	input wire logic        hsync_pin,             // Horizontal sync pin
	input wire logic        clamp_pos_connect,     // Positive input to clamp
	input wire logic        neg_to_clamp,          // Negative input tied
	input wire logic        clamp_active,          // Clamp control
	input wire logic        auto_black_active,     // Auto black running
	input wire logic [2:0]  clamp_level_600mv,     // Clamp levels
	input wire logic [2:0]  half_scale_shift,      // Shifts
	input wire logic [23:0] black_target,          // Black targets
	input wire logic        separate_sync,         // Separate syncs
	input wire logic        composite_sync_signal, // Sync mux output
	input wire logic [29:0] offset_dac,            // Converter words
	input wire logic [26:0] digital_offset,        // Digital offsets
	input wire logic [5:0]  dac_step_shift         // Step sizes
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_dc_off; !neg_to_clamp |-> !clamp_active && !clamp_pos_connect; endproperty
	a_dc_off: assert property (p_dc_off) else $error("clamp on while dc coupled");
	property p_window; clamp_active |-> $past(clamp_interval) && clamp_pos_connect; endproperty
	a_window: assert property (p_window) else $error("clamp outside window");
	property p_autob; auto_black_active && $past(presetn) |-> $past(auto_black_en); endproperty
	a_autob: assert property (p_autob) else $error("auto black without request");
	property p_sep; separate_sync && $past(presetn) |-> composite_sync_signal == $past(hsync_pin);
	endproperty
	a_sep: assert property (p_sep) else $error("sync mux not on pin");
	property p_colour; {clamp_level_600mv, half_scale_shift, black_target} == {6'o07, 24'h0}
		|| {clamp_level_600mv, half_scale_shift, black_target} == {6'o52, 24'h80_0080}; endproperty
	a_colour: assert property (p_colour) else $error("colour space set mixed");
	property p_err; psel && penable && (paddr < 8'h14 || paddr > 8'h33) |-> pslverr && !prdata;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_auto_dac; $past(auto_black_en) && $past(auto_black_en, 2) && $past(presetn, 2)
		|-> offset_dac == {3{10'h200}}; endproperty
	a_auto_dac: assert property (p_auto_dac) else $error("converter not parked");
	property p_man_dig; !$past(auto_black_en) && !$past(auto_black_en, 2) |-> digital_offset == 0;
	endproperty
	a_man_dig: assert property (p_man_dig) else $error("digital offset in manual mode");
	property p_step; (dac_step_shift & 6'b10_1010) == 6'h00; endproperty
	a_step: assert property (p_step) else $error("step shift out of range");
endmodule
bind video_input_gain_offset_config video_cfg_props chk_u (.*);

// ### bench/cfg_host.sv
/* Host model: APB master writing and reading the configuration bank.
   Assumes pready may stall; tasks are called from the bench. */
`timescale 1ns/10ps
module cfg_host (
	input  wire         pclk,               // Clock
	input  wire  [31:0] prdata,             // Read data
	input  wire         pready,             // Ready
	input  wire         pslverr,            // Error
	output logic        psel = 1'b0,        // Select
	output logic        penable = 1'b0,     // Enable
	output logic        pwrite = 1'b0,      // Direction
	output logic [7:0]  paddr = 8'h00,      // Byte address
	output logic [31:0] pwdata = 32'h0000_0000 // Write data
);
	// One transfer: setup, access held until ready, then release with bus flipped
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= {24'h00_0000, (idx == 8'h05) ? wd & 8'h3f :
			(idx == 8'h0c) ? wd & 8'hfd : wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask
endmodule

// ### bench/video_input_gain_offset_config_bench.sv
/* Bench for the configuration bank: register and channel path checks.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module video_input_gain_offset_config_bench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        clamp_interval = 1'b1;
	logic        holdover = 1'b0;
	logic        auto_black_en = 1'b0;
	logic        hsync_pin = 1'b1;
	logic        green_embedded_sync_input = 1'b0;
	wire         psel, penable, pwrite, pready, pslverr, channel_select, clamp_pos_connect;
	wire         neg_to_clamp, clamp_active, auto_black_active, separate_sync;
	wire         composite_sync_signal;
	wire  [7:0]  paddr;
	wire  [31:0] pwdata, prdata;
	wire  [2:0]  clamp_level_600mv, half_scale_shift;
	wire  [23:0] black_target;
	wire  [29:0] gain_num, offset_dac;
	wire  [26:0] digital_offset;
	wire  [5:0]  dac_step_shift;
	logic [7:0]  rd;
	logic        err;
	int          fails = 0;
	int          compares = 0;
	video_input_gain_offset_config dut_u (.*);
	cfg_host host_u (.*);
	// Clock
	always #25 pclk = ~pclk;
	// Write, then wait for the paths to follow
	task automatic put(input logic [7:0] idx, input logic [7:0] v);
		host_u.xfer(1'b1, idx, v, rd, err);
		repeat (3) @(posedge pclk);
	endtask
	// Read and compare {error, data}
	task automatic get(input logic [7:0] idx, input logic [8:0] e);
		host_u.xfer(1'b0, idx, 8'h00, rd, err);
		`CHK({err, rd}, e)
	endtask
	task automatic test_done;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (3000) @(posedge pclk);
		fails++;
		test_done();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 5; i < 13; i++) get(i, {1'b0, (i == 5 || i == 12) ? 8'h00 :
			(i < 9) ? 8'h55 : 8'h80});
		get(8'h0d, 9'h100);
		$display("test reset done");
		put(8'h05, 8'h01);
		`CHK(channel_select, 1'b1)
		`CHK({clamp_active, clamp_pos_connect, neg_to_clamp}, 3'b111)
		`CHK({clamp_level_600mv, half_scale_shift, black_target}, {6'o07, 24'h0})
		`CHK({separate_sync, composite_sync_signal}, 2'b11)
		clamp_interval <= 1'b0;
		hsync_pin <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK({clamp_active, clamp_pos_connect, neg_to_clamp}, 3'b001)
		`CHK(composite_sync_signal, 1'b0)
		clamp_interval <= 1'b1;
		hsync_pin <= 1'b1;
		put(8'h05, 8'h1e);
		`CHK(channel_select, 1'b0)
		`CHK({clamp_active, neg_to_clamp}, 2'b00)
		`CHK({clamp_level_600mv, half_scale_shift, black_target}, {6'o52, 24'h80_0080})
		`CHK({separate_sync, composite_sync_signal}, 2'b01)
		put(8'h05, 8'h0c);
		`CHK(composite_sync_signal, 1'b0)
		holdover <= 1'b1;
		auto_black_en <= 1'b1;
		put(8'h05, 8'h00);
		`CHK({clamp_active, auto_black_active}, 2'b00)
		put(8'h05, 8'h20);
		`CHK({clamp_active, auto_black_active}, 2'b11)
		get(8'h05, 9'h020);
		$display("test inputs done");
		put(8'h06, 8'h00);
		put(8'h07, 8'hff);
		put(8'h08, 8'h55);
		`CHK(gain_num, {10'd340, 10'd680, 10'd170})
		auto_black_en <= 1'b0;
		put(8'h09, 8'h00);
		put(8'h0a, 8'hff);
		put(8'h0b, 8'h80);
		put(8'h0c, 8'he5);
		`CHK(offset_dac, {10'h203, 10'h3fe, 10'h001})
		`CHK({dac_step_shift, digital_offset}, {6'h15, 27'h0})
		auto_black_en <= 1'b1;
		put(8'h0c, 8'h00);
		`CHK(offset_dac, {3{10'h200}})
		`CHK({dac_step_shift, digital_offset}, {6'h00, 9'h000, 9'h07f, 9'h180})
		$display("test offsets done");
		test_done();
	end
endmodule
